// ==== logic/srl_top.sv ====
// configuration and status register bank of the packet switch, with the route lookup
// assumes the fabric and link layers run on sys_clk_i and their inputs are synchronous
// Operation
// RULE_01: eight 4-bit directions for dimensions 0..7, dimension 0 lowest, reset zero
// RULE_02: second register holds directions for dimensions 8..15, reset zero
// RULE_03: route uses direction of most significant differing node-id bit
// RULE_04: link status shows read-only 2-bit endpoint type
// RULE_05: link status shows 8-bit destination link number while in use
// RULE_06: each switch link has writable 4-bit direction, reset zero
// RULE_07: every link has writable 2-bit network field, reset zero
// RULE_08: read-only junk, destination busy and source busy bits per link
// RULE_09: eight processor link registers, same status, no direction field
// RULE_10: control bit 31 enables the external link and its port muxing
// RULE_11: control bit 30 picks 2-wire or 5-wire mode, reset zero
// RULE_12: bit 27 set on receive overflow or illegal token
// RULE_13: bit 26 shows credit granted to remote; no transmit without credit
// RULE_14: bit 25 shows credit held from remote, reset zero
// RULE_15: writing bit 24 clears own credit and sends credit request token
// RULE_16: writing bit 23 resets the receiver to token start
// RULE_17: 11-bit symbol gap field, value is minimum idle clocks minus one
// RULE_18: 11-bit token gap field, value is minimum idle clocks minus one
// RULE_19: static enable bit 31 sends all received traffic to a channel end
// RULE_20: static target processor in bit 8, channel end in bits 4:0
// RULE_21: static registers in address order serve links C, D, A, B, G, H, E, F
// RULE_22: debug source bit 0 or 1 names core of latest debug event
// RULE_23: writable 16-bit node identifier, reset zero, used by routing
// RULE_24: write-protect bit 31 makes the bank ignore all writes
// RULE_25: reserved bits read zero and writes to them do nothing; bank keeps bits 1:0 at OFF_RSV_A, OFF_RSV_B and debug source bit 4
`timescale 1ns/1ns
`default_nettype none
module srl_top
	import srl_pkg::*;
#(
	parameter logic [31:0] USER_CODE_ID_VAL = 32'h0000_0000 // arbitrary value
) (
	// clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     resetn_i,
	// node configuration access
	input  wire srl_pkg::srl_cfg_req_t    cfg_i,
	output logic                          cfg_ack_o,
	output logic [31:0]                   cfg_rdata_o,
	// route lookup
	input  wire logic                     route_req_i,
	input  wire logic [15:0]              route_dest_id_i,
	output logic                          route_vld_o,
	output logic                          route_local_o,
	output logic [3:0]                    route_dir_o,
	// link status from the fabric
	input  wire srl_pkg::srl_lnk_stat_t [7:0] sw_stat_i,
	input  wire srl_pkg::srl_lnk_stat_t [7:0] pl_stat_i,
	// external link layer status
	input  wire logic [7:0]               rx_err_i,
	input  wire logic [7:0]               credit_issued_i,
	input  wire logic [7:0]               credit_held_i,
	// debug events
	input  wire logic                     dbg_evt_i,
	input  wire logic                     dbg_core_i,
	// configuration outputs
	output logic [7:0][3:0]               sw_dir_o,
	output logic [7:0][1:0]               sw_net_o,
	output logic [7:0][1:0]               pl_net_o,
	output srl_pkg::srl_ext_cfg_t [7:0]   ext_cfg_o,
	output logic [7:0]                    credit_clr_o,
	output logic [7:0]                    rx_reset_o,
	output srl_pkg::srl_fwd_cfg_t [7:0]   fwd_cfg_o,
	output logic                          hdr_one_byte_o,
	output logic                          pll_lock_o
);
	import srl_pkg::*;

	// bank state
	logic        lock_r;
	logic [15:0] node_id_r;
	logic [31:0] dir_lo_r;
	logic [31:0] dir_hi_r;
	logic [1:0]  rsv_a_r;
	logic [1:0]  rsv_b_r;
	logic [1:0]  dbg_r;
	logic        dbg_rsv_r;
	logic [7:0]  err_r;
	logic [31:0] rd_mux;

	// access decode
	wire        wr_ok   = cfg_i.req & cfg_i.wr & ~lock_r; // see RULE_24
	wire [4:0]  grp     = cfg_i.addr[7:3];
	wire [2:0]  idx     = cfg_i.addr[2:0];
	wire        in_sw   = (grp == OFF_SW_LNK[7:3]);
	wire        in_pl   = (grp == OFF_PL_LNK[7:3]);
	wire        in_ext  = (grp == OFF_EXT_CTL[7:3]);
	wire        in_st   = (grp == OFF_STATIC[7:3]);
	wire [31:0] wd      = cfg_i.wdata;

	// per-link read words
	logic [7:0][31:0] sw_rd;
	logic [7:0][31:0] pl_rd;
	logic [7:0][31:0] ext_rd;
	logic [7:0][31:0] st_rd;

	// route lookup: highest differing bit picks a nibble of the tables
	function automatic logic [3:0] top_diff(input logic [15:0] d);
		logic [3:0] pos;
		pos = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (d[i]) begin
				pos = 4'(i);
			end
		end
		return pos;
	endfunction : top_diff

	wire [15:0]  id_diff  = route_dest_id_i ^ node_id_r;
	wire [3:0]   dim      = top_diff(id_diff);
	wire [63:0]  dir_tab  = {dir_hi_r, dir_lo_r};          // see RULE_01 see RULE_02
	wire [3:0]   dir_pick = dir_tab[{dim, 2'b00} +: 4];    // see RULE_03

	// route result register
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			route_vld_o   <= 1'b0;
			route_local_o <= 1'b0;
			route_dir_o   <= RST_DIR;
		end else begin
			route_vld_o   <= route_req_i;
			route_local_o <= (id_diff == 16'h0000);
			route_dir_o   <= dir_pick; // see RULE_03
		end
	end

	// global registers
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_r         <= 1'b0;
			pll_lock_o     <= 1'b0;
			hdr_one_byte_o <= 1'b0;
			node_id_r      <= RST_NODE_ID;
			dir_lo_r       <= RST_DIRS;
			dir_hi_r       <= RST_DIRS;
			rsv_a_r        <= RST_RSV;
			rsv_b_r        <= RST_RSV;
			dbg_rsv_r      <= 1'b0;
		end else if (wr_ok) begin
			if (cfg_i.addr == OFF_SW_CFG) begin
				lock_r         <= wd[SWC_LOCK_BIT]; // see RULE_24
				pll_lock_o     <= wd[SWC_PLL_BIT];
				hdr_one_byte_o <= wd[SWC_HDR_BIT];
			end
			if (cfg_i.addr == OFF_NODE_ID) begin
				node_id_r <= wd[15:0]; // see RULE_23
			end
			if (cfg_i.addr == OFF_DIR_LO) begin
				dir_lo_r <= wd; // see RULE_01
			end
			if (cfg_i.addr == OFF_DIR_HI) begin
				dir_hi_r <= wd; // see RULE_02
			end
			if (cfg_i.addr == OFF_RSV_A) begin
				rsv_a_r <= wd[1:0]; // see RULE_25
			end
			if (cfg_i.addr == OFF_RSV_B) begin
				rsv_b_r <= wd[1:0];
			end
			if (cfg_i.addr == OFF_DBG_SRC) begin
				dbg_rsv_r <= wd[DBG_RSV_BIT];
			end
		end
	end

	// debug source: hardware event wins over a software write
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dbg_r <= RST_DBG;
		end else if (dbg_evt_i) begin
			dbg_r <= dbg_core_i ? 2'b10 : 2'b01; // see RULE_22
		end else if (wr_ok && cfg_i.addr == OFF_DBG_SRC) begin
			dbg_r <= wd[1:0];
		end
	end

	// per-link registers
	for (genvar g = 0; g < 8; g++) begin : g_lnk
		localparam int LTR = g ^ 2; // register order C,D,A,B,G,H,E,F
		wire sw_wr  = wr_ok & in_sw  & (idx == 3'(g));
		wire pl_wr  = wr_ok & in_pl  & (idx == 3'(g));
		wire ext_wr = wr_ok & in_ext & (idx == 3'(g));
		wire st_wr  = wr_ok & in_st  & (idx == 3'(g));

		// switch link direction and network, processor link network
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				sw_dir_o[g] <= RST_DIR;
				sw_net_o[g] <= RST_NET;
				pl_net_o[g] <= RST_NET;
			end else begin
				if (sw_wr) begin
					sw_dir_o[g] <= wd[LS_DIR_LSB +: 4]; // see RULE_06
					sw_net_o[g] <= wd[LS_NET_LSB +: 2]; // see RULE_07
				end
				if (pl_wr) begin
					pl_net_o[g] <= wd[LS_NET_LSB +: 2]; // see RULE_07 see RULE_09
				end
			end
		end

		// external link control and strobes
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				ext_cfg_o[g]    <= '{1'b0, 1'b0, RST_GAP, RST_GAP};
				credit_clr_o[g] <= 1'b0;
				rx_reset_o[g]   <= 1'b0;
			end else begin
				credit_clr_o[g] <= ext_wr & wd[XC_CREDIT_REQUEST_TOKEN_BIT]; // see RULE_15
				rx_reset_o[g]   <= ext_wr & wd[XC_RXRST_BIT]; // see RULE_16
				if (ext_wr) begin
					ext_cfg_o[g].enable    <= wd[XC_EN_BIT];          // see RULE_10
					ext_cfg_o[g].five_wire <= wd[XC_WIDE_BIT];        // see RULE_11
					ext_cfg_o[g].sym_gap   <= wd[XC_SGAP_LSB +: 11];  // see RULE_17
					ext_cfg_o[g].tok_gap   <= wd[XC_TGAP_LSB +: 11];  // see RULE_18
				end
			end
		end

		// sticky link error, cleared by receiver reset; a new error wins
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				err_r[g] <= 1'b0;
			end else begin
				err_r[g] <= rx_err_i[g] | (err_r[g] & ~(ext_wr & wd[XC_RXRST_BIT])); // see RULE_12
			end
		end

		// static forwarding, mapped to link letters
		always_ff @(posedge sys_clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				fwd_cfg_o[LTR] <= '{1'b0, 1'b0, RST_CHAN};
			end else if (st_wr) begin
				fwd_cfg_o[LTR].enable  <= wd[SF_EN_BIT];        // see RULE_19 see RULE_21
				fwd_cfg_o[LTR].proc    <= wd[SF_PROC_BIT];      // see RULE_20
				fwd_cfg_o[LTR].chanend <= wd[SF_CHAN_LSB +: 5]; // see RULE_20
			end
		end

		// read words, reserved bits zero
		assign sw_rd[g] = {6'h00, sw_stat_i[g].link_endpoint_type, sw_stat_i[g].dest_link,
			4'h0, sw_dir_o[g], 2'h0, sw_net_o[g], 1'b0, sw_stat_i[g].junk,
			sw_stat_i[g].dst_busy, sw_stat_i[g].src_busy}; // see RULE_04 see RULE_05 see RULE_08
		assign pl_rd[g] = {6'h00, pl_stat_i[g].link_endpoint_type, pl_stat_i[g].dest_link,
			10'h000, pl_net_o[g], 1'b0, pl_stat_i[g].junk,
			pl_stat_i[g].dst_busy, pl_stat_i[g].src_busy}; // see RULE_09
		assign ext_rd[g] = {ext_cfg_o[g].enable, ext_cfg_o[g].five_wire, 2'h0, err_r[g],
			credit_issued_i[g], credit_held_i[g], 3'h0,
			ext_cfg_o[g].sym_gap, ext_cfg_o[g].tok_gap}; // see RULE_13 see RULE_14
		assign st_rd[g] = {fwd_cfg_o[LTR].enable, 22'h000000, fwd_cfg_o[LTR].proc,
			3'h0, fwd_cfg_o[LTR].chanend};
	end

	// read selection; unmapped numbers read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (in_sw) begin
			rd_mux = sw_rd[idx];
		end else if (in_pl) begin
			rd_mux = pl_rd[idx];
		end else if (in_ext) begin
			rd_mux = ext_rd[idx];
		end else if (in_st) begin
			rd_mux = st_rd[idx];
		end else begin
			case (cfg_i.addr)
				OFF_SW_CFG:   rd_mux = {lock_r, 22'h000000, pll_lock_o, 7'h00, hdr_one_byte_o};
				OFF_NODE_ID:  rd_mux = {16'h0000, node_id_r};
				OFF_USER_CODE_ID: rd_mux = USER_CODE_ID_VAL;
				OFF_DIR_LO:   rd_mux = dir_lo_r;
				OFF_DIR_HI:   rd_mux = dir_hi_r;
				OFF_RSV_A:    rd_mux = {30'h00000000, rsv_a_r};
				OFF_RSV_B:    rd_mux = {30'h00000000, rsv_b_r};
				OFF_DBG_SRC:  rd_mux = {27'h0000000, dbg_rsv_r, 2'h0, dbg_r}; // see RULE_22
				default:      rd_mux = 32'h0000_0000; // see RULE_25
			endcase
		end
	end

	// access answer one cycle after the request
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_ack_o   <= 1'b0;
			cfg_rdata_o <= 32'h0000_0000;
		end else begin
			cfg_ack_o   <= cfg_i.req;
			cfg_rdata_o <= (cfg_i.req && !cfg_i.wr) ? rd_mux : 32'h0000_0000;
		end
	end
endmodule : srl_top
`default_nettype wire

// ==== pkg/srl_pkg.sv ====
// constants and carrier types for the switch routing and link configuration bank
// assumes register numbers are 8 bits wide and data words are 32 bits wide
`default_nettype none
package srl_pkg;
	// register numbers
	localparam logic [7:0] OFF_SW_CFG   = 8'h04;
	localparam logic [7:0] OFF_NODE_ID  = 8'h05;
	localparam logic [7:0] OFF_USER_CODE_ID = 8'h0A;
	localparam logic [7:0] OFF_DIR_LO   = 8'h0C;
	localparam logic [7:0] OFF_DIR_HI   = 8'h0D;
	localparam logic [7:0] OFF_RSV_A    = 8'h10;
	localparam logic [7:0] OFF_RSV_B    = 8'h11;
	localparam logic [7:0] OFF_DBG_SRC  = 8'h1F;
	localparam logic [7:0] OFF_SW_LNK   = 8'h20;
	localparam logic [7:0] OFF_PL_LNK   = 8'h40;
	localparam logic [7:0] OFF_EXT_CTL  = 8'h80;
	localparam logic [7:0] OFF_STATIC   = 8'hA0;

	// switch configuration fields
	localparam int SWC_LOCK_BIT = 31;
	localparam int SWC_PLL_BIT  = 8;
	localparam int SWC_HDR_BIT  = 0;

	// link status fields
	localparam int LS_TYPE_LSB  = 24;
	localparam int LS_DEST_LSB  = 16;
	localparam int LS_DIR_LSB   = 8;
	localparam int LS_NET_LSB   = 4;
	localparam int LS_JUNK_BIT  = 2;
	localparam int LS_DBUSY_BIT = 1;
	localparam int LS_SBUSY_BIT = 0;

	// external link control fields
	localparam int XC_EN_BIT     = 31;
	localparam int XC_WIDE_BIT   = 30;
	localparam int XC_ERR_BIT    = 27;
	localparam int XC_CRISS_BIT  = 26;
	localparam int XC_CRHELD_BIT = 25;
	localparam int XC_CREDIT_REQUEST_TOKEN_BIT  = 24;
	localparam int XC_RXRST_BIT  = 23;
	localparam int XC_SGAP_LSB   = 11;
	localparam int XC_TGAP_LSB   = 0;

	// static forwarding fields
	localparam int SF_EN_BIT   = 31;
	localparam int SF_PROC_BIT = 8;
	localparam int SF_CHAN_LSB = 0;

	// debug source fields
	localparam int DBG_RSV_BIT = 4;

	// reset values
	localparam logic [31:0] RST_DIRS    = 32'h0000_0000;
	localparam logic [15:0] RST_NODE_ID = 16'h0000;
	localparam logic [3:0]  RST_DIR     = 4'h0;
	localparam logic [1:0]  RST_NET     = 2'h0;
	localparam logic [10:0] RST_GAP     = 11'h000;
	localparam logic [4:0]  RST_CHAN    = 5'h00;
	localparam logic [1:0]  RST_RSV     = 2'h0;
	localparam logic [1:0]  RST_DBG     = 2'h0;

	// source-target type of a link endpoint
	typedef enum logic [1:0] {
		EP_SWITCH_LINK,
		EP_PROC_LINK,
		EP_SWITCH_CTL,
		EP_UNDEF
	} srl_ep_type_t;

	// live status of one link from the switch fabric
	typedef struct packed {
		srl_ep_type_t link_endpoint_type;
		logic [7:0]   dest_link;
		logic         junk;
		logic         dst_busy;
		logic         src_busy;
	} srl_lnk_stat_t;

	// configuration of one external link
	typedef struct packed {
		logic        enable;
		logic        five_wire;
		logic [10:0] sym_gap;
		logic [10:0] tok_gap;
	} srl_ext_cfg_t;

	// static forwarding target of one external link
	typedef struct packed {
		logic       enable;
		logic       proc;
		logic [4:0] chanend;
	} srl_fwd_cfg_t;

	// node configuration access
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} srl_cfg_req_t;
endpackage : srl_pkg
`default_nettype wire

// ==== testbench/srl_top_sva.sv ====
// assertions on the ports of the configuration bank, and their bind
// assumes one clock domain and direct 8-bit register numbers
`timescale 1ns/1ns
`default_nettype none
module srl_top_sva
	import srl_pkg::*;
(
	// clock and reset
	input wire logic                         sys_clk_i,
	input wire logic                         resetn_i,
	// register access and route
	input wire srl_pkg::srl_cfg_req_t        cfg_i,
	input wire logic [31:0]                  cfg_rdata_o,
	input wire logic                         route_req_i,
	input wire logic                         route_vld_o,
	// link status and configuration
	input wire srl_pkg::srl_lnk_stat_t [7:0] sw_stat_i,
	input wire srl_pkg::srl_ext_cfg_t [7:0]  ext_cfg_o,
	input wire logic [7:0]                   credit_clr_o,
	input wire logic [7:0]                   rx_reset_o,
	input wire srl_pkg::srl_fwd_cfg_t [7:0]  fwd_cfg_o
);
	logic          lock_r, wok_r, rd_r;
	logic [7:0]    wadr_r;
	logic [31:0]   wdat_r;
	srl_lnk_stat_t stat_r;
	wire logic     wok = cfg_i.req && cfg_i.wr && !lock_r;
	wire logic     ext_w = wok_r && wadr_r[7:3] == 5'h10;
	// shadow of the lock and of the last write or status read
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			lock_r <= 1'h0;
			wok_r <= 1'h0;
			rd_r <= 1'h0;
		end else begin
			lock_r <= lock_r || (wok && cfg_i.addr == OFF_SW_CFG && cfg_i.wdata[31]);
			wok_r <= wok;
			rd_r <= cfg_i.req && !cfg_i.wr && cfg_i.addr[7:3] == 5'h04;
		end
	end
	// data shadows, qualified by the flags above
	always_ff @(posedge sys_clk_i) begin
		wadr_r <= cfg_i.addr;
		wdat_r <= cfg_i.wdata;
		stat_r <= sw_stat_i[cfg_i.addr[2:0]];
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	property p_route; route_req_i |=> route_vld_o; endproperty
	property p_clr; credit_clr_o == ((ext_w && wdat_r[24]) ? 8'h01 << wadr_r[2:0] : 8'h00); endproperty
	property p_rxr; rx_reset_o == ((ext_w && wdat_r[23]) ? 8'h01 << wadr_r[2:0] : 8'h00); endproperty
	property p_ext; ext_w |-> ext_cfg_o[wadr_r[2:0]] == {wdat_r[31:30], wdat_r[21:0]}; endproperty
	property p_fwd;
		wok_r && wadr_r[7:3] == 5'h14 |-> fwd_cfg_o[wadr_r[2:0] ^ 3'h2] == {wdat_r[31], wdat_r[8], wdat_r[4:0]};
	endproperty
	property p_stat;
		rd_r |-> cfg_rdata_o[25:16] == {stat_r.link_endpoint_type, stat_r.dest_link}
			&& cfg_rdata_o[2:0] == {stat_r.junk, stat_r.dst_busy, stat_r.src_busy};
	endproperty
	property p_rsvd; rd_r |-> {cfg_rdata_o[31:26], cfg_rdata_o[15:12], cfg_rdata_o[7:6], cfg_rdata_o[3]} == 13'h0; endproperty
	property p_lock;
		lock_r && cfg_i.req && cfg_i.wr |=> $stable(fwd_cfg_o) && $stable(ext_cfg_o) && credit_clr_o == 8'h00;
	endproperty
	a_route: assert property (p_route) else $error("route result missing");
	a_clr: assert property (p_clr) else $error("credit clear strobe wrong");
	a_rxr: assert property (p_rxr) else $error("receiver reset strobe wrong");
	a_ext: assert property (p_ext) else $error("link control not stored");
	a_fwd: assert property (p_fwd) else $error("static target wrong");
	a_stat: assert property (p_stat) else $error("link status wrong");
	a_rsvd: assert property (p_rsvd) else $error("reserved status bits set");
	a_lock: assert property (p_lock) else $error("locked write took effect");
	c_lock: cover property (lock_r && cfg_i.req && cfg_i.wr);
	c_fwd: cover property (wok_r && wadr_r[7:3] == 5'h14);
	c_clr: cover property (credit_clr_o != 8'h00);
endmodule : srl_top_sva
bind srl_top srl_top_sva i_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_i(cfg_i),
	.cfg_rdata_o(cfg_rdata_o), .route_req_i(route_req_i), .route_vld_o(route_vld_o), .sw_stat_i(sw_stat_i),
	.ext_cfg_o(ext_cfg_o), .credit_clr_o(credit_clr_o), .rx_reset_o(rx_reset_o), .fwd_cfg_o(fwd_cfg_o));
`default_nettype wire

// ==== testbench/srl_remote_link.sv ====
// model of the remote switches beyond the eight external links
// assumes strobes and link settings come straight from the bank
`timescale 1ns/1ns
`default_nettype none
module srl_remote_link
	import srl_pkg::*;
#(
	parameter int FAST = 4,
	parameter int SLOW = 12
) (
	// clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        resetn_i,
	// from the local end
	input  wire logic [7:0]                  credit_clr_i,
	input  wire srl_pkg::srl_ext_cfg_t [7:0] ext_cfg_i,
	input  wire logic [7:0]                  err_cmd_i,
	// link layer status back
	output logic [7:0]                       credit_held_o,
	output logic [7:0]                       credit_issued_o,
	output logic [7:0]                       rx_err_o
);
	logic [3:0] cnt_r [8];
	// odd links regrant credit slowly, even links promptly
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			credit_held_o <= 8'h00;
			credit_issued_o <= 8'h00;
			rx_err_o <= 8'h00;
			for (int n = 0; n < 8; n++) begin
				cnt_r[n] <= 4'h0;
			end
		end else begin
			rx_err_o <= err_cmd_i; // faults only on command
			for (int n = 0; n < 8; n++) begin
				credit_issued_o[n] <= ext_cfg_i[n].enable;
				if (credit_clr_i[n]) begin
					credit_held_o[n] <= 1'h0;
					cnt_r[n] <= n[0] ? 4'(SLOW) : 4'(FAST);
				end else if (cnt_r[n] != 4'h0) begin
					cnt_r[n] <= cnt_r[n] - 4'h1;
					credit_held_o[n] <= cnt_r[n] == 4'h1 && ext_cfg_i[n].enable;
				end
			end
		end
	end
endmodule : srl_remote_link
`default_nettype wire

// ==== testbench/switch_route_link_config_tb.sv ====
// self-checking bench for the routing and link configuration bank
// assumes the package, the bank, its checker and the remote model
`timescale 1ns/1ns
`default_nettype none
module switch_route_link_config_tb;
	import srl_pkg::*;
	logic clk, rstn, ack, rreq, rvld, rloc, dbg_evt, dbg_core, hdr, pll;
	logic [3:0] rdir;
	logic [15:0] rdst, nid, dst;
	logic [31:0] rdata, rnd, rd, w, lo, hi;
	logic [7:0] err, iss, held, clr, rxr, err_cmd, clr_q, rxr_q, wen;
	srl_cfg_req_t cfg;
	srl_lnk_stat_t [7:0] sws, pls;
	srl_ext_cfg_t [7:0] ext, ext_q;
	srl_fwd_cfg_t [7:0] fwd, fwd_q;
	logic [7:0][3:0] swd;
	logic [7:0][1:0] swn, pln;
	logic [7:0] ra [9] = '{8'h0C, 8'h0D, 8'h05, 8'h20, 8'h80, 8'hA0, 8'h1F, 8'h10, 8'h11};
	logic [7:0] ua [4] = '{8'h10, 8'h28, 8'h88, 8'h30};
	int failures, checks_done;
	srl_top i_dut (.sys_clk_i(clk), .resetn_i(rstn), .cfg_i(cfg), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
		.route_req_i(rreq), .route_dest_id_i(rdst), .route_vld_o(rvld), .route_local_o(rloc),
		.route_dir_o(rdir), .sw_stat_i(sws), .pl_stat_i(pls), .rx_err_i(err), .credit_issued_i(iss),
		.credit_held_i(held), .dbg_evt_i(dbg_evt), .dbg_core_i(dbg_core), .sw_dir_o(swd), .sw_net_o(swn),
		.pl_net_o(pln), .ext_cfg_o(ext), .credit_clr_o(clr), .rx_reset_o(rxr), .fwd_cfg_o(fwd),
		.hdr_one_byte_o(hdr), .pll_lock_o(pll));
	srl_remote_link i_remote (.sys_clk_i(clk), .resetn_i(rstn), .credit_clr_i(clr), .ext_cfg_i(ext),
		.err_cmd_i(err_cmd), .credit_held_o(held), .credit_issued_o(iss), .rx_err_o(err));
	// repeatable stimulus source
	function automatic logic [31:0] lfsr();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return rnd;
	endfunction : lfsr
	// direction of the highest differing node-id bit
	function automatic logic [3:0] dir_exp(logic [15:0] a, logic [15:0] b, logic [63:0] d);
		int k;
		k = 0;
		for (int i = 0; i < 16; i++) if (a[i] != b[i]) k = i;
		return d[k*4 +: 4];
	endfunction : dir_exp
	// expected link status word
	function automatic logic [31:0] st_exp(srl_lnk_stat_t s, logic [31:0] v, logic sw);
		return {6'h0, s[12:3], 4'h0, sw ? v[11:8] : 4'h0, 2'h0, v[5:4], 1'h0, s[2:0]};
	endfunction : st_exp
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one register access, request held over its taking edge
	task automatic acc(logic wr, logic [7:0] a, logic [31:0] d);
		@(posedge clk) #1;
		cfg = '{1'h1, wr, a, d};
		@(posedge clk) #1;
		cfg.req = 1'h0;
		rd = rdata;
		clr_q = clr;
		rxr_q = rxr;
		chk("ack", {31'h0, ack}, 32'h1);
	endtask : acc
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	// clock
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// watchdog, far beyond the expected run
	initial begin
		#40000;
		failures++;
		report_and_stop();
	end
	// main sequence
	initial begin
		{rstn, rreq, rdst, dbg_evt, dbg_core, err_cmd, sws, pls} = '0;
		cfg = '0;
		rnd = 32'h0000_0035;
		failures = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		#1 rstn = 1'h1;
		foreach (ra[i]) begin
			acc(1'h0, ra[i], 32'h0);
			chk("reset", rd, 32'h0);
		end
		lo = lfsr();
		hi = lfsr();
		w = lfsr();
		nid = w[15:0];
		acc(1'h1, 8'h0C, lo);
		acc(1'h1, 8'h0D, hi);
		acc(1'h1, 8'h05, {16'hFFFF, nid});
		acc(1'h0, 8'h05, 32'h0);
		chk("node", rd, {16'h0, nid});
		for (int k = 0; k < 17; k++) begin
			w = lfsr();
			dst = (k == 16) ? nid : (nid ^ (16'h1 << k)) ^ (w[15:0] & ((16'h1 << k) - 16'h1));
			@(posedge clk) #1;
			rreq = 1'h1;
			rdst = dst;
			@(posedge clk) #1;
			rreq = 1'h0;
			chk("route", {26'h0, rvld, rloc, rdir}, {26'h0, 1'h1, dst == nid, dir_exp(nid, dst, {hi, lo})});
		end
		for (int i = 0; i < 8; i++) begin
			w = lfsr();
			sws[i] = w[12:0];
			pls[i] = w[28:16];
			acc(1'h1, 8'h20 + 8'(i), w);
			acc(1'h1, 8'h40 + 8'(i), w);
			acc(1'h0, 8'h20 + 8'(i), 32'h0);
			chk("sw_stat", rd, st_exp(sws[i], w, 1'h1));
			acc(1'h0, 8'h40 + 8'(i), 32'h0);
			chk("pl_stat", rd, st_exp(pls[i], w, 1'h0));
			chk("nets", {24'h0, swd[i], swn[i], pln[i]}, {24'h0, w[11:8], w[5:4], w[5:4]});
			w = lfsr() | 32'h0180_0000;
			wen[i] = w[31];
			acc(1'h1, 8'h80 + 8'(i), w);
			chk("strobes", {16'h0, clr_q, rxr_q}, {16'h0, 8'h1 << i, 8'h1 << i});
			acc(1'h0, 8'h80 + 8'(i), 32'h0);
			chk("ext_ctl", rd, {w[31:30], 3'h0, w[31], 4'h0, w[21:0]});
			w = lfsr();
			acc(1'h1, 8'hA0 + 8'(i), w);
			chk("fwd", {25'h0, fwd[i ^ 2]}, {25'h0, w[31], w[8], w[4:0]});
		end
		repeat (20) @(posedge clk);
		#1 err_cmd = 8'h05;
		@(posedge clk) #1;
		err_cmd = 8'h00;
		for (int i = 0; i < 8; i++) begin
			acc(1'h0, 8'h80 + 8'(i), 32'h0);
			chk("held", {30'h0, rd[27], rd[25]}, {30'h0, i == 0 || i == 2, wen[i]});
		end
		for (int c = 0; c < 2; c++) begin
			@(posedge clk) #1;
			dbg_evt = 1'h1;
			dbg_core = c[0];
			@(posedge clk) #1;
			dbg_evt = 1'h0;
			acc(1'h0, 8'h1F, 32'h0);
			chk("dbg", rd, 32'h1 << c);
		end
		foreach (ua[i]) begin
			acc(1'h1, ua[i], 32'hFFFF_FFFF);
			acc(1'h0, ua[i], 32'h0);
			chk("rsvd", rd, i == 0 ? 32'h3 : 32'h0);
		end
		acc(1'h1, 8'h04, 32'h0000_0101);
		acc(1'h0, 8'h04, 32'h0);
		chk("sw_cfg", rd, 32'h0000_0101);
		chk("sw_pins", {30'h0, pll, hdr}, 32'h3);
		ext_q = ext;
		fwd_q = fwd;
		acc(1'h1, 8'h04, 32'h8000_0000);
		acc(1'h1, 8'h0C, ~lo);
		acc(1'h1, 8'h80, 32'hFFFF_FFFF);
		chk("lock_strobe", {16'h0, clr_q, rxr_q}, 32'h0);
		acc(1'h1, 8'hA0, 32'hFFFF_FFFF);
		acc(1'h0, 8'h0C, 32'h0);
		chk("lock", rd, lo);
		chk("lock_cfg", {1'h0, ext[0], fwd[2]}, {1'h0, ext_q[0], fwd_q[2]});
		report_and_stop();
	end
endmodule : switch_route_link_config_tb
`default_nettype wire
